//--- brf_pkg.sv
// package: constants for the banked register file decoder
// How it works
// [RQ1] bank zero is the full standard file, all 256 byte locations defined
// [RQ2] banks C and F implement only group 0, addresses 00h to 0Fh
// [RQ3] the other thirteen banks are unimplemented and reserved
// [RQ4] with a non-zero bank, addresses 00h-0Fh reach that bank's registers
// [RQ5] addresses 10h and above always map to the standard file
// [RQ6] pointer low nibble at FDh selects the active bank
// [RQ7] pointer high nibble selects the working register group
// [RQ8] low nibble 0000 selects the standard file, same as bank zero
// [RQ9] pointer 0Fh: r0, r11, r15 reach port config, stop, watchdog regs
// [RQ10] bank C holds spi compare, buffer and control at 00h, 01h, 02h
// [RQ11] bank zero: ports 00h-03h, general 04h-EFh, control F0h-FFh
// [RQ12] the program counter has no register file address
// [RQ13] working refs with group zero reach the bank, others standard groups
// [RQ14] software restores bank zero before using ports or low standard regs
// [RQ15] standard control registers reachable by every register instruction
// [RQ16] reading a write-only register returns FFh
// [RQ17] reading the pointer returns the selected bank in its low nibble
// [RQ18] unimplemented bank locations read FFh and ignore writes
package brf_pkg;
  localparam logic [7:0] BRF_PTR_ADDR = 8'h0_0FD;
  localparam logic [7:0] BRF_LOW_LIMIT = 8'h0_010;
  localparam logic [7:0] BRF_READ_ONES = 8'h0_0FF;
  localparam logic [7:0] BRF_PTR_RESET = 8'h0_000;
  localparam logic [7:0] BRF_REG_RESET = 8'h0_000;
  localparam logic [3:0] BRF_BANK_STD = 4'h0;
  localparam logic [3:0] BRF_BANK_SPI = 4'hC;
  localparam logic [3:0] BRF_BANK_CTL = 4'hF;
  // bank C locations
  localparam logic [3:0] BRF_SPI_COMPARE_OFS = 4'h0;
  localparam logic [3:0] BRF_SPI_BUFFER_OFS = 4'h1;
  localparam logic [3:0] BRF_SPI_CONTROL_OFS = 4'h2;
  // bank F locations
  localparam logic [3:0] BRF_PORT_CONFIG_OFS = 4'h0;
  localparam logic [3:0] BRF_STOP_MODE_OFS = 4'hB;
  localparam logic [3:0] BRF_WATCHDOG_MODE_OFS = 4'hF;
  // write-only standard locations
  localparam logic [7:0] BRF_WO_SINGLE = 8'h0_0F3;
  localparam logic [7:0] BRF_WO_FIRST = 8'h0_0F5;
  localparam logic [7:0] BRF_WO_LAST = 8'h0_0F9;
  // expanded register slots: 0..2 bank C, 3..5 bank F
  localparam int BRF_EXP_NUM = 6;
endpackage

//--- brf_decoder.sv
// module: banked register file decoder with storage
`timescale 1ns/1ns
module brf_decoder
  import brf_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  input wire logic ACC_EN_IN,
  input wire logic ACC_WR_IN,
  input wire logic ACC_WORKING_IN,
  input wire logic [7:0] ACC_ADDR_IN,
  input wire logic [7:0] ACC_WDATA_IN,
  output logic [7:0] ACC_RDATA_OUT,
  output logic ACC_RVALID_OUT,
  output logic [3:0] ACTIVE_BANK_OUT,
  output logic [3:0] ACTIVE_GROUP_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [255:0][7:0] std_mem;
    logic [BRF_EXP_NUM-1:0][7:0] exp_mem;
    logic [7:0] rdata;
    logic rvalid;
  } brf_state_t;

  brf_state_t st_q;
  brf_state_t st_d;

  // expanded slot index for bank/offset; 7 means unimplemented
  function automatic logic [2:0] exp_slot(input logic [3:0] bank,
                                          input logic [3:0] ofs);
    logic [2:0] s;
    s = 3'd7;
    if (bank == BRF_BANK_SPI) begin // RQ10
      if (ofs == BRF_SPI_COMPARE_OFS) s = 3'd0;
      if (ofs == BRF_SPI_BUFFER_OFS) s = 3'd1;
      if (ofs == BRF_SPI_CONTROL_OFS) s = 3'd2;
    end
    if (bank == BRF_BANK_CTL) begin // RQ9
      if (ofs == BRF_PORT_CONFIG_OFS) s = 3'd3;
      if (ofs == BRF_STOP_MODE_OFS) s = 3'd4;
      if (ofs == BRF_WATCHDOG_MODE_OFS) s = 3'd5;
    end
    return s;
  endfunction

  function automatic logic write_only(input logic [7:0] a);
    return (a == BRF_WO_SINGLE) || (a >= BRF_WO_FIRST && a <= BRF_WO_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ptr;
  logic [3:0] bank;
  logic [7:0] phys;
  logic low_area;
  logic [2:0] slot;
  logic exp_hit;

  always_comb begin
    ptr = st_q.std_mem[BRF_PTR_ADDR];
    bank = ptr[3:0]; // RQ6 RQ8
    // working refs: group nibble joins 4-bit reference; no program counter
    phys = ACC_WORKING_IN ? {ptr[7:4], ACC_ADDR_IN[3:0]} // RQ7 RQ13 RQ12
                          : ACC_ADDR_IN;
    low_area = (phys < BRF_LOW_LIMIT) && (bank != BRF_BANK_STD); // RQ4 RQ5
    slot = exp_slot(bank, phys[3:0]); // RQ2 RQ3
    exp_hit = low_area && (slot != 3'd7);
  end

  always_comb begin
    st_d = st_q;
    st_d.rvalid = ACC_EN_IN && !ACC_WR_IN;
    st_d.rdata = st_q.rdata;
    if (ACC_EN_IN && ACC_WR_IN) begin
      if (exp_hit) begin
        st_d.exp_mem[slot] = ACC_WDATA_IN; // RQ4
      end else if (!low_area) begin
        st_d.std_mem[phys] = ACC_WDATA_IN; // RQ1 RQ11 RQ15
      end
      // unimplemented low locations drop the write  RQ18
    end
    if (ACC_EN_IN && !ACC_WR_IN) begin
      if (exp_hit) begin
        st_d.rdata = st_q.exp_mem[slot];
      end else if (low_area) begin
        st_d.rdata = BRF_READ_ONES; // RQ18 RQ3
      end else if (write_only(phys)) begin
        st_d.rdata = BRF_READ_ONES; // RQ16
      end else begin
        st_d.rdata = st_q.std_mem[phys]; // RQ17 RQ1
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ACC_RDATA_OUT = st_q.rdata;
  assign ACC_RVALID_OUT = st_q.rvalid;
  assign ACTIVE_BANK_OUT = st_q.std_mem[BRF_PTR_ADDR][3:0];
  assign ACTIVE_GROUP_OUT = st_q.std_mem[BRF_PTR_ADDR][7:4];

  ////////////////////////////////////////////////////////////////////////////
  a_wo_reads_ones: assert property ( // RQ16
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && !ACC_WORKING_IN && write_only(ACC_ADDR_IN)
    |=> ACC_RVALID_OUT && ACC_RDATA_OUT == BRF_READ_ONES)
    else $error("write-only read not FFh");

  a_unimpl_reads_ones: assert property ( // RQ18
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && low_area && !exp_hit
    |=> ACC_RDATA_OUT == BRF_READ_ONES)
    else $error("unimplemented bank read not FFh");

  a_ptr_bank_read: assert property ( // RQ17
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && !ACC_WORKING_IN && ACC_ADDR_IN == BRF_PTR_ADDR
    |=> ACC_RDATA_OUT[3:0] == $past(bank))
    else $error("pointer read lost bank");

  a_bank_write_back: assert property ( // RQ4
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && exp_hit ##1
    ACC_EN_IN && !ACC_WR_IN && exp_hit && slot == $past(slot)
    |=> ACC_RDATA_OUT == $past(ACC_WDATA_IN, 2))
    else $error("bank register readback wrong");

  a_high_std: assert property ( // RQ5
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && phys >= BRF_LOW_LIMIT && !write_only(phys)
    |=> ACC_RDATA_OUT == $past(st_q.std_mem[phys]))
    else $error("high address left standard file");

  a_bank_select: assert property ( // RQ6
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && !ACC_WORKING_IN && ACC_ADDR_IN == BRF_PTR_ADDR
    |=> ACTIVE_BANK_OUT == $past(ACC_WDATA_IN[3:0])
        && ACTIVE_GROUP_OUT == $past(ACC_WDATA_IN[7:4]))
    else $error("pointer write not applied");

  a_std_bank_low: assert property ( // RQ8
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && bank == BRF_BANK_STD && phys < BRF_LOW_LIMIT
    |=> ACC_RDATA_OUT == $past(st_q.std_mem[phys]))
    else $error("bank zero diverted low area");

  a_group_map: assert property ( // RQ13
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && ACC_WORKING_IN && ptr[7:4] != 4'h0
    && !write_only(phys) |=> ACC_RDATA_OUT == $past(st_q.std_mem[phys]))
    else $error("nonzero group reached bank");

  a_read_valid: assert property ( // RQ1
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN
    |=> ACC_RVALID_OUT)
    else $error("read gave no valid pulse");

  a_write_no_valid: assert property ( // RQ1
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN
    |=> !ACC_RVALID_OUT)
    else $error("write gave a valid pulse");

  a_idle_no_valid: assert property ( // RQ1
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    !ACC_EN_IN
    |=> !ACC_RVALID_OUT)
    else $error("idle cycle gave a valid pulse");

  a_rdata_holds: assert property ( // RQ1
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    !(ACC_EN_IN && !ACC_WR_IN)
    |=> $stable(ACC_RDATA_OUT))
    else $error("read data moved without a read");

  a_spi_compare_map: assert property ( // RQ10
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_SPI && phys == {4'h0, BRF_SPI_COMPARE_OFS}
    |-> exp_hit && slot == 3'd0)
    else $error("spi compare not decoded");

  a_spi_buffer_map: assert property ( // RQ10
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_SPI && phys == {4'h0, BRF_SPI_BUFFER_OFS}
    |-> exp_hit && slot == 3'd1)
    else $error("spi buffer not decoded");

  a_spi_control_map: assert property ( // RQ10
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_SPI && phys == {4'h0, BRF_SPI_CONTROL_OFS}
    |-> exp_hit && slot == 3'd2)
    else $error("spi control not decoded");

  a_port_cfg_map: assert property ( // RQ9
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_CTL && phys == {4'h0, BRF_PORT_CONFIG_OFS}
    |-> exp_hit && slot == 3'd3)
    else $error("port config not decoded");

  a_stop_mode_map: assert property ( // RQ9
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_CTL && phys == {4'h0, BRF_STOP_MODE_OFS}
    |-> exp_hit && slot == 3'd4)
    else $error("stop mode not decoded");

  a_watchdog_map: assert property ( // RQ9
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_CTL && phys == {4'h0, BRF_WATCHDOG_MODE_OFS}
    |-> exp_hit && slot == 3'd5)
    else $error("watchdog mode not decoded");

  a_bank_reserved: assert property ( // RQ3
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank != BRF_BANK_STD && bank != BRF_BANK_SPI && bank != BRF_BANK_CTL
    |-> !exp_hit)
    else $error("reserved bank decoded");

  a_ctl_reserved: assert property ( // RQ2
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_CTL && phys[3:0] != BRF_PORT_CONFIG_OFS
    && phys[3:0] != BRF_STOP_MODE_OFS && phys[3:0] != BRF_WATCHDOG_MODE_OFS
    |-> !exp_hit)
    else $error("reserved control bank slot decoded");

  a_spi_reserved: assert property ( // RQ2
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    bank == BRF_BANK_SPI && phys[3:0] > BRF_SPI_CONTROL_OFS
    |-> !exp_hit)
    else $error("reserved spi bank slot decoded");

  a_unimpl_write_drop: assert property ( // RQ18
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && low_area && !exp_hit
    |=> st_q.std_mem == $past(st_q.std_mem)
        && st_q.exp_mem == $past(st_q.exp_mem))
    else $error("unimplemented write changed storage");

  a_std_write_lands: assert property ( // RQ11
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && !low_area
    |=> st_q.std_mem[$past(phys)] == $past(ACC_WDATA_IN))
    else $error("standard write lost");

  a_exp_write_lands: assert property ( // RQ4
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && exp_hit
    |=> st_q.exp_mem[$past(slot)] == $past(ACC_WDATA_IN))
    else $error("bank write lost");

  a_exp_write_std_kept: assert property ( // RQ4
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && exp_hit
    |=> st_q.std_mem == $past(st_q.std_mem))
    else $error("bank write touched standard file");

  a_std_write_exp_kept: assert property ( // RQ5
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && !exp_hit
    |=> st_q.exp_mem == $past(st_q.exp_mem))
    else $error("standard write touched bank");

  a_working_read: assert property ( // RQ7
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && ACC_WORKING_IN && !low_area && !write_only(phys)
    |=> ACC_RDATA_OUT == $past(st_q.std_mem[{ptr[7:4], ACC_ADDR_IN[3:0]}]))
    else $error("working read used wrong group");

  a_exp_read_data: assert property ( // RQ4
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && exp_hit
    |=> ACC_RDATA_OUT == $past(st_q.exp_mem[slot]))
    else $error("bank read wrong");

  a_pointer_kept: assert property ( // RQ6
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    !(ACC_EN_IN && ACC_WR_IN && !low_area && phys == BRF_PTR_ADDR)
    |=> $stable(ACTIVE_BANK_OUT) && $stable(ACTIVE_GROUP_OUT))
    else $error("pointer moved without a write");

  a_ptr_working_write: assert property ( // RQ15
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && ACC_WORKING_IN && phys == BRF_PTR_ADDR
    |=> ACTIVE_BANK_OUT == $past(ACC_WDATA_IN[3:0]))
    else $error("working pointer write lost");

  a_ctl_reg_read: assert property ( // RQ15
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && phys >= 8'hF0 && !write_only(phys)
    |=> ACC_RDATA_OUT == $past(st_q.std_mem[phys]))
    else $error("control register read wrong");

  a_wo_working: assert property ( // RQ16
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && ACC_WORKING_IN && write_only(phys)
    |=> ACC_RDATA_OUT == BRF_READ_ONES)
    else $error("working write-only read not FFh");

  a_ptr_reads_full: assert property ( // RQ17
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && phys == BRF_PTR_ADDR
    |=> ACC_RDATA_OUT == $past(ptr))
    else $error("pointer read wrong");

  a_idle_keeps_std: assert property ( // RQ1
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    !ACC_EN_IN
    |=> st_q.std_mem == $past(st_q.std_mem))
    else $error("idle cycle changed standard file");

  a_idle_keeps_exp: assert property ( // RQ2
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    !ACC_EN_IN
    |=> st_q.exp_mem == $past(st_q.exp_mem))
    else $error("idle cycle changed bank");

  a_read_keeps_std: assert property ( // RQ1
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN
    |=> st_q.std_mem == $past(st_q.std_mem))
    else $error("read changed standard file");

  a_read_keeps_exp: assert property ( // RQ4
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN
    |=> st_q.exp_mem == $past(st_q.exp_mem))
    else $error("read changed bank");

  a_unimpl_working: assert property ( // RQ18
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && !ACC_WR_IN && ACC_WORKING_IN && low_area && !exp_hit
    |=> ACC_RDATA_OUT == BRF_READ_ONES)
    else $error("unimplemented working read not FFh");

  a_bank_zero_write: assert property ( // RQ8
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && bank == BRF_BANK_STD && phys < BRF_LOW_LIMIT
    |=> st_q.std_mem[$past(phys)] == $past(ACC_WDATA_IN))
    else $error("bank zero low write lost");

  a_high_write_lands: assert property ( // RQ5
    @(posedge MCLK_IN) disable iff (!RSTN_IN)
    ACC_EN_IN && ACC_WR_IN && phys >= BRF_LOW_LIMIT
    |=> st_q.std_mem[$past(phys)] == $past(ACC_WDATA_IN))
    else $error("high write lost");
endmodule // brf_decoder

//--- brf_core_model.sv
// partner: core side access driver for the register file decoder
`timescale 1ns/1ns
module brf_core_model (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output logic en_out,
  output logic wr_out,
  output logic wk_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    {en_out, wr_out, wk_out, addr_out, wdata_out} = '0;
  end
  // one access per call, enable dropped and address and data lines scrambled when released
  task automatic acc(input logic w, k, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(posedge clk_in);
    #1;
    {en_out, wr_out, wk_out, addr_out, wdata_out} = {1'b1, w, k, a, d};
    @(posedge clk_in);
    #1;
    en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
    q = rvalid_in ? rdata_in : 8'bx;
  endtask
  // write then read of the same place on the next cycle
  task automatic acc_pair(input logic k, input logic [7:0] a, d,
                          output logic [7:0] q);
    @(posedge clk_in);
    #1;
    {en_out, wr_out, wk_out, addr_out, wdata_out} = {1'b1, 1'b1, k, a, d};
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    @(posedge clk_in);
    #1;
    en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
    q = rvalid_in ? rdata_in : 8'bx;
  endtask
endmodule // brf_core_model

//--- tb.sv
// testbench: self-checking bench for the banked register file decoder
`timescale 1ns/1ns
module tb;
  import brf_pkg::*;
  logic clk, rst_n, en, wr, wk, rv;
  logic [7:0] a, d, q, rd;
  logic [3:0] bank, grp;
  int failures, samples_checked;
  brf_decoder i_dut (.MCLK_IN(clk), .RSTN_IN(rst_n), .ACC_EN_IN(en),
    .ACC_WR_IN(wr), .ACC_WORKING_IN(wk), .ACC_ADDR_IN(a),
    .ACC_WDATA_IN(d), .ACC_RDATA_OUT(rd), .ACC_RVALID_OUT(rv),
    .ACTIVE_BANK_OUT(bank), .ACTIVE_GROUP_OUT(grp));
  brf_core_model i_core (.clk_in(clk), .rvalid_in(rv), .rdata_in(rd),
    .en_out(en), .wr_out(wr), .wk_out(wk), .addr_out(a), .wdata_out(d));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic k, input logic [7:0] ad, dv);
    i_core.acc(1'b1, k, ad, dv, q);
  endtask
  task automatic rd_chk(input logic k, input logic [7:0] ad, ex);
    i_core.acc(1'b0, k, ad, 8'h00, q);
    chk(q, ex);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_pointer;
    wr_reg(0, BRF_PTR_ADDR, 8'h7C);
    chk({grp, bank}, 8'h7C);
    rd_chk(0, BRF_PTR_ADDR, 8'h7C);
  endtask
  task automatic t_bank_c;
    wr_reg(0, BRF_PTR_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) wr_reg(0, 8'(i), 8'h10 + 8'(i));
    wr_reg(0, BRF_PTR_ADDR, 8'h0C);
    for (int i = 0; i < 3; i++) wr_reg(0, 8'(i), 8'hA0 + 8'(i));
    wr_reg(0, 8'h03, 8'h55);
    for (int i = 0; i < 3; i++) rd_chk(0, 8'(i), 8'hA0 + 8'(i));
    rd_chk(0, 8'h03, 8'hFF);
    wr_reg(0, BRF_PTR_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(0, 8'(i), 8'h10 + 8'(i));
  endtask
  task automatic t_bank_f;
    wr_reg(0, 8'h10, 8'h3C);
    wr_reg(0, 8'hF0, 8'h77);
    wr_reg(0, BRF_PTR_ADDR, 8'h0F);
    wr_reg(1, 8'h00, 8'hC0);
    wr_reg(1, 8'h0B, 8'hCB);
    wr_reg(1, 8'h0F, 8'hCF);
    rd_chk(0, 8'h00, 8'hC0);
    rd_chk(0, 8'h0B, 8'hCB);
    rd_chk(1, 8'h0F, 8'hCF);
    rd_chk(0, 8'h01, 8'hFF);
    rd_chk(0, 8'h10, 8'h3C);
    wr_reg(0, BRF_PTR_ADDR, 8'hFF);
    rd_chk(1, 8'h00, 8'h77);
  endtask
  task automatic t_misc;
    wr_reg(0, BRF_PTR_ADDR, 8'h05);
    wr_reg(0, 8'h00, 8'h99);
    rd_chk(0, 8'h00, 8'hFF);
    wr_reg(0, BRF_PTR_ADDR, 8'h00);
    rd_chk(0, 8'h00, 8'h10);
    wr_reg(0, 8'hF3, 8'h12);
    rd_chk(0, 8'hF3, 8'hFF);
    rd_chk(0, 8'hEF, 8'h00);
  endtask
  task automatic t_back_to_back;
    wr_reg(0, BRF_PTR_ADDR, 8'h0C);
    i_core.acc_pair(0, 8'h01, 8'h5A, q);
    chk(q, 8'h5A);
    wr_reg(0, BRF_PTR_ADDR, 8'h00);
    i_core.acc_pair(0, 8'h20, 8'hA5, q);
    chk(q, 8'hA5);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    t_pointer();
    t_bank_c();
    t_bank_f();
    t_misc();
    t_back_to_back();
    end_of_test();
  end
endmodule // tb
